// ==== core/tcp_pkg.sv ====
// Package with register map, fields, reset values and carriers of the prescaled timer/counter
// How it works
// - Counter advances only while the run-control bit is set.
// - Width-select set gives an 8-bit counter, clear gives 16 bits.
// - Source-select set counts pin transitions, clear counts instruction cycles.
// - Edge-select set counts falling pin edges, clear counts rising edges.
// - Bypass set feeds counter directly, clear feeds it through the prescaler.
// - Ratio field 000 divides by 2, each step doubles, 111 divides by 256.
// - Control register resets to all ones.
// - Internal source without prescaler increments once per instruction cycle.
// - A counter write inhibits incrementing for the next two instruction cycles.
// - Pin input is synchronised before counting, adding some delay.
// - Prescaler is an 8-bit counter hidden from software.
// - Counter write clears prescaler count but keeps its assignment.
// - Prescaler assignment may change at any time while counting.
// - Overflow flag sets on wrap FFh to 00h or FFFFh to 0000h.
// - Overflow request is gated by the overflow enable bit.
// - Overflow cannot wake from sleep; counting stops while clocks stop.
// - Low-byte read copies the live high byte into the high buffer.
// - Low-byte write loads the high byte from the buffer in 16-bit mode.
package tcp_pkg;
	localparam logic [11:0] TCP_ADDR_LOW  = 12'h000;
	localparam logic [11:0] TCP_ADDR_HIGH = 12'h004;
	localparam logic [11:0] TCP_ADDR_CTRL = 12'h008;
	localparam logic [11:0] TCP_ADDR_INT  = 12'h00C;
	localparam logic [7:0]  TCP_CTRL_RST  = 8'hFF;
	localparam logic [7:0]  TCP_HIGH_RST  = 8'h00;
	localparam int          TCP_RUN_BIT   = 7;
	localparam int          TCP_W8_BIT    = 6;
	localparam int          TCP_SRC_BIT   = 5;
	localparam int          TCP_EDGE_BIT  = 4;
	localparam int          TCP_BYP_BIT   = 3;
	localparam int          TCP_FLAG_BIT  = 2;
	localparam int          TCP_IEN_BIT   = 5;
	localparam logic [1:0]  TCP_HOLD_CYC  = 2'h2;
	localparam logic [3:0]  TCP_ICYC_DIV  = 4'h4;

	typedef struct packed {
		logic [1:0]  pin_sync;
		logic        pin_last;
		logic [3:0]  div_cnt;
		logic [7:0]  presc;
		logic [15:0] count;
		logic [7:0]  high_buf;
		logic [7:0]  ctrl;
		logic        ovf_flag;
		logic        ovf_en;
		logic [1:0]  hold;
		logic [31:0] prdata;
	} tcp_state_s;
endpackage : tcp_pkg

// ==== core/tcp_timer.sv ====
// APB timer/counter, 8 or 16 bits, with prescaler, edge select and overflow flag
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tcp_timer import tcp_pkg::*; #(
	parameter logic [3:0] ICYC_DIV = TCP_ICYC_DIV
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	input  wire logic        ext_count_pin,
	output logic             ovf_irq,
	output logic [15:0]      count_value
);
	tcp_state_s q, d;
	logic acc, wr, rd, icyc, ev, tick, wrap, hit;
	logic [15:0] nxt;

	// Ratio decode: 2^(field+1) events per tick
	function automatic logic [7:0] ratio_max(input logic [2:0] f);
		ratio_max = 8'((9'h002 << f) - 9'h001);
	endfunction : ratio_max

	// Register select
	function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
		is_addr = (a == r);
	endfunction : is_addr

	// APB access phase with zero wait states
	assign acc     = psel && penable;
	assign wr      = acc && pwrite && pstrb[0];
	assign rd      = acc && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = acc && !(is_addr(paddr, TCP_ADDR_LOW) || is_addr(paddr, TCP_ADDR_HIGH)
		|| is_addr(paddr, TCP_ADDR_CTRL) || is_addr(paddr, TCP_ADDR_INT));
	assign prdata      = q.prdata;
	assign ovf_irq     = q.ovf_flag && q.ovf_en;
	assign count_value = q.count;

	// Next-state logic
	always_comb begin
		d = q;
		d.pin_sync = {q.pin_sync[0], ext_count_pin};
		d.pin_last = q.pin_sync[1];
		icyc = !sleep_mode && (q.div_cnt == ICYC_DIV - 4'h1);
		d.div_cnt = sleep_mode ? q.div_cnt : (icyc ? 4'h0 : q.div_cnt + 4'h1);
		// Source and edge selection
		if (q.ctrl[TCP_SRC_BIT]) begin
			ev = q.ctrl[TCP_EDGE_BIT] ? (q.pin_last && !q.pin_sync[1])
				: (!q.pin_last && q.pin_sync[1]);
			ev = ev && !sleep_mode;
		end else begin
			ev = icyc;
		end
		ev = ev && q.ctrl[TCP_RUN_BIT];
		// Prescaler counts events only while not bypassed; an assignment change keeps its count
		hit = (q.presc == ratio_max(q.ctrl[2:0]));
		if (q.ctrl[TCP_BYP_BIT]) begin
			tick = ev;
		end else begin
			tick = ev && hit;
			if (ev) begin
				d.presc = hit ? 8'h00 : q.presc + 8'h01;
			end
		end
		// Two-cycle write inhibit counted in instruction cycles
		if (q.hold != 2'h0 && icyc) begin
			d.hold = q.hold - 2'h1;
		end
		tick = tick && (q.hold == 2'h0);
		nxt  = q.count + 16'h0001;
		wrap = 1'b0;
		if (tick) begin
			if (q.ctrl[TCP_W8_BIT]) begin
				d.count[7:0] = nxt[7:0];
				wrap = (q.count[7:0] == 8'hFF);
			end else begin
				d.count = nxt;
				wrap = (q.count == 16'hFFFF);
			end
		end
		// Register writes
		if (wr) begin
			if (is_addr(paddr, TCP_ADDR_LOW)) begin
				d.count[7:0] = pwdata[7:0];
				if (!q.ctrl[TCP_W8_BIT]) begin
					d.count[15:8] = q.high_buf;
				end
				d.presc = 8'h00;
				d.hold  = TCP_HOLD_CYC;
			end
			if (is_addr(paddr, TCP_ADDR_HIGH)) begin
				d.high_buf = pwdata[7:0];
			end
			if (is_addr(paddr, TCP_ADDR_CTRL)) begin
				d.ctrl = pwdata[7:0];
			end
			if (is_addr(paddr, TCP_ADDR_INT)) begin
				d.ovf_en   = pwdata[TCP_IEN_BIT];
				d.ovf_flag = pwdata[TCP_FLAG_BIT];
			end
		end
		if (wrap) begin
			d.ovf_flag = 1'b1; // set wins over clear
		end
		// Read data and high-byte snapshot
		d.prdata = 32'h0000_0000;
		if (rd) begin
			if (is_addr(paddr, TCP_ADDR_LOW)) begin
				d.prdata[7:0] = q.count[7:0];
				d.high_buf    = q.count[15:8];
			end
			if (is_addr(paddr, TCP_ADDR_HIGH)) begin
				d.prdata[7:0] = q.high_buf;
			end
			if (is_addr(paddr, TCP_ADDR_CTRL)) begin
				d.prdata[7:0] = q.ctrl;
			end
			if (is_addr(paddr, TCP_ADDR_INT)) begin
				d.prdata[TCP_IEN_BIT]  = q.ovf_en;
				d.prdata[TCP_FLAG_BIT] = q.ovf_flag;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q          <= '0;
			q.ctrl     <= TCP_CTRL_RST;
			q.high_buf <= TCP_HIGH_RST;
		end else begin
			q <= d;
		end
	end

	// Checks
	chk_ctrl_reset: assert property (@(posedge pclk) $rose(presetn) |-> q.ctrl == TCP_CTRL_RST)
		else $error("control not all ones after reset");
	chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!q.ctrl[TCP_RUN_BIT] && !wr |=> $stable(q.count))
		else $error("counter moved while stopped");
	chk_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> q.ovf_flag)
		else $error("overflow flag not set on wrap");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		q.ovf_flag && !(wr && is_addr(paddr, TCP_ADDR_INT)) |=> q.ovf_flag)
		else $error("flag dropped without clear");
	chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_irq |-> q.ovf_en && q.ovf_flag)
		else $error("interrupt not gated");
	chk_write_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) |=> !tick [*2])
		else $error("increment right after write");
	chk_high_snap: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_LOW) |=> q.high_buf == $past(q.count[15:8]))
		else $error("high buffer not captured");
	chk_high_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) && !q.ctrl[TCP_W8_BIT]
		|=> q.count[15:8] == $past(q.high_buf))
		else $error("high byte not loaded");
	chk_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) |=> q.presc == 8'h00)
		else $error("prescaler not cleared");
	chk_w8_high: assert property (@(posedge pclk) disable iff (!presetn)
		q.ctrl[TCP_W8_BIT] && !wr |=> $stable(q.count[15:8]))
		else $error("high byte moved in 8-bit mode");

	// Register writes land in the next cycle
	chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_CTRL) |=> q.ctrl == $past(pwdata[7:0]))
		else $error("control write lost");

	chk_high_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_HIGH) |=> q.high_buf == $past(pwdata[7:0]))
		else $error("high buffer write lost");

	chk_low_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) |=> q.count[7:0] == $past(pwdata[7:0]))
		else $error("low byte write lost");

	chk_ien_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_INT) |=> q.ovf_en == $past(pwdata[TCP_IEN_BIT]))
		else $error("overflow enable write lost");

	chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_INT) && !pwdata[TCP_FLAG_BIT] && !wrap
		|=> !q.ovf_flag)
		else $error("flag clear lost");

	chk_w8_keep: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) && q.ctrl[TCP_W8_BIT] |=> $stable(q.count[15:8]))
		else $error("high byte loaded in 8-bit mode");

	chk_hold_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_addr(paddr, TCP_ADDR_LOW) |=> q.hold == TCP_HOLD_CYC)
		else $error("inhibit not armed");

	chk_refused_wr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && pslverr |=> $stable(q.ctrl) && $stable(q.high_buf) && $stable(q.ovf_en))
		else $error("unmapped write changed state");

	// Read data stands one cycle and is zero otherwise
	chk_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!rd |=> q.prdata == 32'h0000_0000)
		else $error("read data not idle");

	chk_read_low: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_LOW) |=> q.prdata == {24'h00_0000, $past(q.count[7:0])})
		else $error("low byte read wrong");

	chk_read_high: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_HIGH) |=> q.prdata == {24'h00_0000, $past(q.high_buf)})
		else $error("high buffer read wrong");

	chk_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_CTRL) |=> q.prdata == {24'h00_0000, $past(q.ctrl)})
		else $error("control read wrong");

	chk_read_flag: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_INT) |=> q.prdata[TCP_FLAG_BIT] == $past(q.ovf_flag))
		else $error("flag read wrong");

	chk_read_ien: assert property (@(posedge pclk) disable iff (!presetn)
		rd && is_addr(paddr, TCP_ADDR_INT) |=> q.prdata[TCP_IEN_BIT] == $past(q.ovf_en))
		else $error("enable read wrong");

	chk_refused_rd: assert property (@(posedge pclk) disable iff (!presetn)
		rd && pslverr |=> q.prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	chk_presc_hidden: assert property (@(posedge pclk) disable iff (!presetn)
		rd |=> q.prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	// Instruction-cycle divider and sleep
	chk_div_range: assert property (@(posedge pclk) disable iff (!presetn)
		q.div_cnt < ICYC_DIV)
		else $error("divider out of range");

	chk_icyc_end: assert property (@(posedge pclk) disable iff (!presetn)
		icyc |-> q.div_cnt == ICYC_DIV - 4'h1)
		else $error("instruction cycle early");

	chk_div_step: assert property (@(posedge pclk) disable iff (!presetn)
		!sleep_mode && !icyc |=> q.div_cnt == $past(q.div_cnt) + 4'h1)
		else $error("divider skipped");

	chk_div_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		icyc |=> q.div_cnt == 4'h0)
		else $error("divider did not restart");

	chk_sleep_icyc: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode |-> !icyc)
		else $error("instruction cycle in sleep");

	chk_sleep_div: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode |=> $stable(q.div_cnt))
		else $error("divider ran in sleep");

	chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode && !wr |=> $stable(q.count))
		else $error("counter ran in sleep");

	chk_sleep_tick: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode |-> !tick)
		else $error("tick in sleep");

	// Pin path, source and write inhibit
	chk_sync_stage: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> q.pin_sync[1] == $past(q.pin_sync[0]))
		else $error("synchroniser skipped a stage");

	chk_sync_last: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> q.pin_last == $past(q.pin_sync[1]))
		else $error("edge history wrong");

	chk_pin_edge: assert property (@(posedge pclk) disable iff (!presetn)
		tick && q.ctrl[TCP_SRC_BIT] |-> q.pin_last != q.pin_sync[1])
		else $error("pin tick without edge");

	chk_edge_pol: assert property (@(posedge pclk) disable iff (!presetn)
		tick && q.ctrl[TCP_SRC_BIT] |-> q.pin_sync[1] == !q.ctrl[TCP_EDGE_BIT])
		else $error("pin tick on wrong edge");

	chk_pin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		q.ctrl[TCP_SRC_BIT] && q.pin_last == q.pin_sync[1] |-> !tick)
		else $error("pin tick while pin steady");

	chk_int_src: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !q.ctrl[TCP_SRC_BIT] |-> icyc)
		else $error("internal tick off cycle");

	chk_tick_run: assert property (@(posedge pclk) disable iff (!presetn)
		tick |-> q.ctrl[TCP_RUN_BIT])
		else $error("tick while stopped");

	chk_tick_hold: assert property (@(posedge pclk) disable iff (!presetn)
		tick |-> q.hold == 2'h0)
		else $error("tick during inhibit");

	chk_hold_step: assert property (@(posedge pclk) disable iff (!presetn)
		q.hold != 2'h0 && icyc && !wr |=> q.hold == $past(q.hold) - 2'h1)
		else $error("inhibit did not count down");

	chk_hold_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!icyc && !wr |=> $stable(q.hold))
		else $error("inhibit moved off cycle");

	// Prescaler
	chk_byp_presc: assert property (@(posedge pclk) disable iff (!presetn)
		q.ctrl[TCP_BYP_BIT] && !wr |=> $stable(q.presc))
		else $error("prescaler ran while bypassed");

	chk_byp_tick: assert property (@(posedge pclk) disable iff (!presetn)
		q.ctrl[TCP_BYP_BIT] && ev && q.hold == 2'h0 |-> tick)
		else $error("bypassed event lost");

	chk_presc_hit: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !q.ctrl[TCP_BYP_BIT] |-> q.presc == ratio_max(q.ctrl[2:0]))
		else $error("prescaled tick before ratio");

	chk_presc_zero: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !q.ctrl[TCP_BYP_BIT] && !wr |=> q.presc == 8'h00)
		else $error("prescaler did not restart");

	chk_presc_step: assert property (@(posedge pclk) disable iff (!presetn)
		ev && !hit && !q.ctrl[TCP_BYP_BIT] && !wr |=> q.presc == $past(q.presc) + 8'h01)
		else $error("prescaler missed an event");

	chk_presc_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!ev && !wr |=> $stable(q.presc))
		else $error("prescaler moved without event");

	chk_presc_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!q.ctrl[TCP_BYP_BIT] && !hit |-> !tick)
		else $error("prescaler passed early event");

	// Counter and overflow
	chk_inc8: assert property (@(posedge pclk) disable iff (!presetn)
		tick && q.ctrl[TCP_W8_BIT] && !wr |=> q.count[7:0] == $past(q.count[7:0]) + 8'h01)
		else $error("8-bit increment wrong");

	chk_inc16: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !q.ctrl[TCP_W8_BIT] && !wr |=> q.count == $past(q.count) + 16'h0001)
		else $error("16-bit increment wrong");

	chk_wrap8: assert property (@(posedge pclk) disable iff (!presetn)
		tick && q.ctrl[TCP_W8_BIT] && q.count[7:0] == 8'hFF |-> wrap)
		else $error("8-bit wrap missed");

	chk_wrap16: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !q.ctrl[TCP_W8_BIT] && q.count == 16'hFFFF |-> wrap)
		else $error("16-bit wrap missed");

	chk_wrap_tick: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |-> tick)
		else $error("wrap without tick");

	chk_flag_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!q.ovf_flag && !wrap && !(wr && is_addr(paddr, TCP_ADDR_INT)) |=> !q.ovf_flag)
		else $error("flag set without wrap");

	chk_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
		!q.ovf_en |-> !ovf_irq)
		else $error("masked interrupt seen");

	chk_count_rest: assert property (@(posedge pclk) disable iff (!presetn)
		!tick && !wr |=> $stable(q.count))
		else $error("counter moved without tick");

	cov_wrap8: cover property (@(posedge pclk) wrap && q.ctrl[TCP_W8_BIT]);
	cov_wrap16: cover property (@(posedge pclk) wrap && !q.ctrl[TCP_W8_BIT]);
	cov_presc_tick: cover property (@(posedge pclk) tick && !q.ctrl[TCP_BYP_BIT]);
	cov_pin_tick: cover property (@(posedge pclk) tick && q.ctrl[TCP_SRC_BIT]);
	cov_presc_clr: cover property (@(posedge pclk)
		wr && is_addr(paddr, TCP_ADDR_LOW) && !q.ctrl[TCP_BYP_BIT]);
endmodule : tcp_timer
`default_nettype wire

// ==== tb/tcp_pin_src.sv ====
// Model of the external count source driving the count pin
`timescale 1ns/100ps
`default_nettype none
module tcp_pin_src (
	input  wire logic pclk,
	output logic      pin
);
	// Pin idles low; each level holds four clocks so the synchroniser sees it
	initial pin = 1'b0;
	task toggle(input int n);
		repeat (n) begin
			@(posedge pclk);
			pin <= ~pin;
			repeat (3) @(posedge pclk);
		end
	endtask : toggle
endmodule : tcp_pin_src
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the prescaled timer/counter
`timescale 1ns/100ps
`default_nettype none
module testbench import tcp_pkg::*; ();
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, sleep_mode = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, lfsr = 32'hABB33620, prdata;
	logic        pready, pslverr, ovf_irq, ext_pin;
	logic [15:0] count_value;
	logic [31:0] exp_q[$];
	int          num_errors = 0, n_tests = 0;
	always #50 pclk = ~pclk;
	tcp_timer #(.ICYC_DIV(4'h4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.ext_count_pin(ext_pin), .ovf_irq(ovf_irq), .count_value(count_value));
	tcp_pin_src pm_u (.pclk(pclk), .pin(ext_pin));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// One APB transfer, held until pready is sampled high, then one idle cycle
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	task test_done;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// Every access checks its error flag; read data lands a cycle later, compared mid-cycle
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1)
			chk("pslverr", {31'h0, paddr > TCP_ADDR_INT}, {31'h0, pslverr});
		if (psel && penable && !pwrite && pready === 1'b1) begin
			@(negedge pclk);
			chk("prdata", exp_q.pop_front(), prdata);
		end
	end
	// Watchdog well beyond the expected run length
	initial begin
		#3000000;
		num_errors++;
		test_done();
	end
	initial begin
		int k;
		int r;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(TCP_ADDR_CTRL, 32'hFF);
		rd(TCP_ADDR_HIGH, 32'h0);
		apb(12'h010, 1'b1, 32'hFF);
		rd(12'h010, 32'h0);
		$display("Test reset values done");
		apb(TCP_ADDR_CTRL, 1'b1, 32'h08);
		apb(TCP_ADDR_HIGH, 1'b1, 32'hA5);
		apb(TCP_ADDR_LOW, 1'b1, 32'h3C);
		apb(TCP_ADDR_HIGH, 1'b1, 32'h00);
		chk("count", 32'hA53C, {16'h0, count_value});
		rd(TCP_ADDR_LOW, 32'h3C);
		rd(TCP_ADDR_HIGH, 32'hA5);
		$display("Test 16-bit buffer done");
		// Stopped, then running but asleep: a random count must hold
		for (k = 0; k < 2; k++) begin
			lfsr = lfsr_next(lfsr);
			sleep_mode <= k[0];
			apb(TCP_ADDR_CTRL, 1'b1, k ? 32'hC8 : 32'h48);
			apb(TCP_ADDR_LOW, 1'b1, {24'h0, lfsr[7:0]});
			repeat (40) @(posedge pclk);
			rd(TCP_ADDR_LOW, {24'h0, lfsr[7:0]});
		end
		sleep_mode <= 1'b0;
		$display("Test stop and sleep done");
		// Overflow in 16-bit mode, then in 8-bit mode
		for (k = 0; k < 2; k++) begin
			apb(TCP_ADDR_INT, 1'b1, 32'h20);
			apb(TCP_ADDR_CTRL, 1'b1, k ? 32'hC8 : 32'h88);
			apb(TCP_ADDR_HIGH, 1'b1, 32'hFF);
			apb(TCP_ADDR_LOW, 1'b1, 32'hFE);
			repeat (40) @(posedge pclk);
			rd(TCP_ADDR_INT, 32'h24);
			chk("irq", 32'h1, {31'h0, ovf_irq});
			apb(TCP_ADDR_INT, 1'b1, 32'h04);
			chk("irq", 32'h0, {31'h0, ovf_irq});
			apb(TCP_ADDR_INT, 1'b1, 32'h00);
			rd(TCP_ADDR_INT, 32'h0);
		end
		$display("Test overflow done");
		// Five pin toggles give three rising edges, then three falling ones
		for (k = 0; k < 2; k++) begin
			apb(TCP_ADDR_CTRL, 1'b1, k ? 32'hF8 : 32'hE8);
			apb(TCP_ADDR_LOW, 1'b1, 32'h0);
			repeat (12) @(posedge pclk);
			pm_u.toggle(5);
			repeat (10) @(posedge pclk);
			rd(TCP_ADDR_LOW, 32'h3);
		end
		$display("Test pin edges done");
		// One extra rise leaves a residue that the next counter write clears
		for (r = 0; r < 8; r++) begin
			apb(TCP_ADDR_CTRL, 1'b1, 32'hE0 | {29'h0, r[2:0]});
			apb(TCP_ADDR_LOW, 1'b1, 32'h0);
			repeat (12) @(posedge pclk);
			pm_u.toggle((8 << r) + 2);
			repeat (10) @(posedge pclk);
			rd(TCP_ADDR_LOW, 32'h2);
		end
		$display("Test prescaler done");
		// Reset in mid-run brings control back to all ones and the count to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(TCP_ADDR_CTRL, 32'hFF);
		rd(TCP_ADDR_LOW, 32'h0);
		$display("Test mid-run reset done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
